//--- design/led_pwm_consts.vh
/*
  Constants of the LED PWM intensity block: register indices, field
  positions, reset values and timing figures.
  Assumes it is included by bare name from every design file.
*/
`ifndef LED_PWM_CONSTS_VH
`define LED_PWM_CONSTS_VH

// Register indices; byte address is four times the index
`define IDX_INPUT_PORT 8'h00
`define IDX_PHASE0 8'h01
`define IDX_PHASE1 8'h09
`define IDX_MASTER 8'h0e
`define IDX_CONFIG 8'h0f
`define IDX_INTENSITY_FIRST 8'h10
`define IDX_INTENSITY_LAST 8'h13
`define IDX_STATUS 8'h20

// Configuration register fields
`define CFG_BLINK_EN 0
`define CFG_BLINK_FLIP 1
`define CFG_GLOBAL 2
`define CFG_NINTH_PH0 4
`define CFG_NINTH_PH1 5
`define CFG_WIDTH 6

// Status register fields
`define STS_SUB_LSB 0
`define STS_SLOT_LSB 4
`define STS_ACTIVE 8

// Reset values
`define RST_MASTER 8'h00
`define RST_PHASE 8'hff
`define RST_INTENSITY 8'hff
`define RST_CONFIG 6'h30

// Intensity code meaning static
`define CODE_STATIC 4'hf

// PWM frame: 15 timeslots of 16 cycles, 240 steps
`define SLOT_LAST 4'he
`define SUB_LAST 4'hf

// Oscillator step rate and clock rate in Hz
`define CLK_HZ 40000000
`define OSC_HZ 32000

// AHB transfer type bit for NONSEQ/SEQ
`define HTRANS_ACTIVE 1

`endif

//--- design/led_pwm_intensity_control.v
/*
  LED PWM intensity controller with AHB-Lite register access and nine
  open-drain outputs.
  Assumes a single AHB-Lite master, one clock, and external pull-ups on
  the output pins; pin inputs arrive asynchronously.
*/
// Chosen here: the AHB-Lite slave port.
`include "led_pwm_consts.vh"

// Summary of operation
// - A master field of zero makes every output static, ignoring global and individual codes.
// - A master value from 0x10 to 0xff runs PWM timing for outputs whose codes select PWM.
// - With PWM on and the global flag clear each output uses its own 4-bit code.
// - With PWM on and the global flag set all outputs use the ninth-output code only.
// - An individual code of all ones makes that output static while others pulse.
// - An individual code from 0 to 14 pulse-width modulates the output by that code.
// - With phase bit clear, code n drives low for (n+1)/16 and releases the rest.
// - With phase bit set, code n drives low for (15-n)/16 and releases for (n+1)/16.
// - Code fifteen holds the output low with phase clear and released with phase set.
// - The PWM frame is 240 steps made of 15 timeslots of 16 cycles.
// - The master value gates PWM to 1 through 15 timeslots of each frame.
// - A full-scale code ignores master gating and follows the phase bit statically.
// - With blink disabled the phase-0 bit sets the level during on-time.
module led_pwm_intensity_control #(
  parameter STEP_DIV = `CLK_HZ / `OSC_HZ,
  parameter NUM_OUT = 9
) (
  input wire CLK,
  input wire RST,
  input wire HSEL,
  input wire [31:0] HADDR,
  input wire [1:0] HTRANS,
  input wire HWRITE,
  input wire [2:0] HSIZE,
  input wire [31:0] HWDATA,
  input wire HREADY,
  output reg [31:0] HRDATA,
  output reg HREADYOUT,
  output reg HRESP,
  input wire [NUM_OUT-1:0] PORT_IN,
  output reg [NUM_OUT-1:0] PORT_OUT,
  output wire [NUM_OUT-1:0] PORT_OE
);
  // Register index from a byte address
  function [7:0] reg_index;
    input [31:0] addr;
    begin
      reg_index = addr[9:2];
    end
  endfunction

  // Intensity register hit: index names the n-th output pair register
  function intensity_hit;
    input [7:0] idx;
    input [7:0] n;
    begin
      intensity_hit = idx == `IDX_INTENSITY_FIRST + n;
    end
  endfunction

  // Software registers
  reg [7:0] master_and_ninth_intensity;
  reg [7:0] output_intensity [0:3];
  reg [7:0] phase0;
  reg [7:0] phase1;
  reg [`CFG_WIDTH-1:0] config_bits;

  // Shadow copies used by the PWM logic
  reg [7:0] shadow_master;
  reg [31:0] shadow_codes;
  reg shadow_global;

  // Pin input synchroniser
  reg [NUM_OUT-1:0] pin_meta;
  reg [NUM_OUT-1:0] pin_sync;

  // Bus data phase state
  reg wr_pending;
  reg [7:0] wr_index;

  wire take;
  wire [7:0] addr_index;
  wire [3:0] slot;
  wire [3:0] sub;
  wire frame_end;
  wire pwm_off;
  wire live_off;
  wire load_shadow;
  wire [NUM_OUT-1:0] drive_low;
  wire [NUM_OUT-1:0] phase_sel;
  reg [31:0] next_rdata;
  integer i;

  assign take = HSEL && HREADY && HTRANS[`HTRANS_ACTIVE];
  assign addr_index = reg_index(HADDR);

  // Master field in the upper nibble decides static versus PWM
  assign pwm_off = shadow_master[7:4] == 4'h0;
  assign live_off = master_and_ninth_intensity[7:4] == 4'h0;
  // Shadows reload at frame end, and at once while PWM is stopped
  assign load_shadow = frame_end || pwm_off;

  // Open-drain: enable high while pulling the pin low
  assign PORT_OE = PORT_OUT;

  // Two-flop synchroniser on the pin inputs
  always @(posedge CLK) begin
    if (RST) begin
      pin_meta <= {NUM_OUT{1'b0}};
      pin_sync <= {NUM_OUT{1'b0}};
    end else begin
      pin_meta <= PORT_IN;
      pin_sync <= pin_meta;
    end
  end

  // Address phase capture; slave always ready, always OKAY
  always @(posedge CLK) begin
    if (RST) begin
      wr_pending <= 1'b0;
      wr_index <= 8'h00;
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end else begin
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
      if (HREADY) begin
        wr_pending <= take && HWRITE;
        wr_index <= addr_index;
      end
    end
  end

  // Register writes in the data phase; unmapped writes are dropped
  always @(posedge CLK) begin
    if (RST) begin
      master_and_ninth_intensity <= `RST_MASTER;
      phase0 <= `RST_PHASE;
      phase1 <= `RST_PHASE;
      config_bits <= `RST_CONFIG;
      for (i = 0; i < 4; i = i + 1) begin
        output_intensity[i] <= `RST_INTENSITY;
      end
    end else if (wr_pending) begin
      case (wr_index)
        `IDX_MASTER: master_and_ninth_intensity <= HWDATA[7:0];
        `IDX_PHASE0: phase0 <= HWDATA[7:0];
        `IDX_PHASE1: phase1 <= HWDATA[7:0];
        `IDX_CONFIG: config_bits <= HWDATA[`CFG_WIDTH-1:0];
        default: begin
          for (i = 0; i < 4; i = i + 1) begin
            if (intensity_hit(wr_index, i[7:0])) begin
              output_intensity[i] <= HWDATA[7:0];
            end
          end
        end
      endcase
    end
  end

  // Read mux, evaluated from the address phase
  always @* begin
    next_rdata = 32'h00000000;
    case (addr_index)
      `IDX_INPUT_PORT: next_rdata[NUM_OUT-1:0] = pin_sync;
      `IDX_PHASE0: next_rdata[7:0] = phase0;
      `IDX_PHASE1: next_rdata[7:0] = phase1;
      `IDX_MASTER: next_rdata[7:0] = master_and_ninth_intensity;
      `IDX_CONFIG: next_rdata[`CFG_WIDTH-1:0] = config_bits;
      `IDX_STATUS: begin
        next_rdata[`STS_SUB_LSB+3:`STS_SUB_LSB] = sub;
        next_rdata[`STS_SLOT_LSB+3:`STS_SLOT_LSB] = slot;
        next_rdata[`STS_ACTIVE] = ~pwm_off;
      end
      default: begin
        for (i = 0; i < 4; i = i + 1) begin
          if (intensity_hit(addr_index, i[7:0])) begin
            next_rdata[7:0] = output_intensity[i];
          end
        end
      end
    endcase
  end

  // Read data register, loaded when a read is accepted
  always @(posedge CLK) begin
    if (RST) begin
      HRDATA <= 32'h00000000;
    end else if (take && !HWRITE) begin
      HRDATA <= next_rdata;
    end
  end

  // Shadow intensity settings; a new frame picks up the live values
  always @(posedge CLK) begin
    if (RST) begin
      shadow_master <= `RST_MASTER;
      shadow_codes <= {4{`RST_INTENSITY}};
      shadow_global <= 1'b0;
    end else if (load_shadow || live_off) begin
      shadow_master <= master_and_ninth_intensity;
      shadow_codes <= {output_intensity[3], output_intensity[2],
                       output_intensity[1], output_intensity[0]};
      shadow_global <= config_bits[`CFG_GLOBAL];
    end
  end

  // Frame timebase, held cleared while PWM is disabled
  pwm_timebase #(
    .STEP_DIV(STEP_DIV)
  ) u_timebase (
    .clk(CLK),
    .rst(RST),
    .hold(pwm_off),
    .step(),
    .frame_end(frame_end),
    .slot(slot),
    .sub(sub)
  );

  // Phase register selection: phase 1 only when blink enabled and flipped
  genvar g;
  generate
    for (g = 0; g < NUM_OUT; g = g + 1) begin : g_out
      wire use_ph1;
      wire [3:0] code;
      assign use_ph1 = config_bits[`CFG_BLINK_EN] && config_bits[`CFG_BLINK_FLIP];
      if (g == NUM_OUT - 1) begin : g_ninth
        assign phase_sel[g] = use_ph1 ? config_bits[`CFG_NINTH_PH1]
                                      : config_bits[`CFG_NINTH_PH0];
        assign code = shadow_master[3:0];
      end else begin : g_port
        assign phase_sel[g] = use_ph1 ? phase1[g] : phase0[g];
        // Global flag swaps every individual code for the ninth code
        assign code = shadow_global ? shadow_master[3:0]
                                    : shadow_codes[4*g+3:4*g];
      end
      pwm_channel u_channel (
        .clk(CLK),
        .rst(RST),
        .pwm_off(pwm_off),
        .master(shadow_master[7:4]),
        .code(code),
        .phase(phase_sel[g]),
        .slot(slot),
        .sub(sub),
        .drive_low(drive_low[g])
      );
    end
  endgenerate

  // Pin drive: PORT_OUT is the registered drive-low, and the enable copies it
  always @(posedge CLK) begin
    if (RST) begin
      PORT_OUT <= {NUM_OUT{1'b0}};
    end else begin
      PORT_OUT <= drive_low;
    end
  end
endmodule // led_pwm_intensity_control

//--- design/pwm_channel.v
/*
  One open-drain output: turns its intensity code, phase bit and master
  gate into a registered drive-low enable.
  Assumes slot and sub only move on timebase steps.
*/
`include "led_pwm_consts.vh"

module pwm_channel (
  input wire clk,
  input wire rst,
  input wire pwm_off,
  input wire [3:0] master,
  input wire [3:0] code,
  input wire phase,
  input wire [3:0] slot,
  input wire [3:0] sub,
  output reg drive_low
);
  wire gate;
  wire on_time;

  // Master gate opens the first 'master' timeslots of a frame
  assign gate = slot < master;
  // On-time lasts code+1 of the 16 cycles
  assign on_time = gate && (sub <= code);

  // Static levels follow the phase bit, PWM flips on-time level
  always @(posedge clk) begin
    if (rst) begin
      drive_low <= 1'b0;
    end else if (pwm_off || code == `CODE_STATIC) begin
      drive_low <= ~phase;
    end else if (phase) begin
      drive_low <= ~on_time;
    end else begin
      drive_low <= on_time;
    end
  end
endmodule // pwm_channel

//--- design/pwm_timebase.v
/*
  PWM timebase: divides the clock into oscillator steps and counts the
  240-step frame as 15 timeslots of 16 cycles.
  Assumes a single clock and a synchronous active-high clear.
*/
`include "led_pwm_consts.vh"

module pwm_timebase #(
  parameter STEP_DIV = `CLK_HZ / `OSC_HZ
) (
  input wire clk,
  input wire rst,
  input wire hold,
  output reg step,
  output reg frame_end,
  output reg [3:0] slot,
  output reg [3:0] sub
);
  reg [15:0] div;

  // Step divider and frame counters; held cleared while PWM is off
  always @(posedge clk) begin
    if (rst || hold) begin
      div <= 16'h0000;
      step <= 1'b0;
      frame_end <= 1'b0;
      slot <= 4'h0;
      sub <= 4'h0;
    end else begin
      step <= 1'b0;
      frame_end <= 1'b0;
      if (div == STEP_DIV[15:0] - 16'h0001) begin
        div <= 16'h0000;
        step <= 1'b1;
        if (sub == `SUB_LAST) begin
          sub <= 4'h0;
          if (slot == `SLOT_LAST) begin
            slot <= 4'h0;
            frame_end <= 1'b1;
          end else begin
            slot <= slot + 4'h1;
          end
        end else begin
          sub <= sub + 4'h1;
        end
      end else begin
        div <= div + 16'h0001;
      end
    end
  end
endmodule // pwm_timebase

//--- verification/led_pin_loads.sv
/* Pin model: nine open-drain lines, each with a pull-up resistor.
   Assumes enable high means the block pulls the line low. */
module led_pin_loads (
  input wire [8:0] drive_en,
  output wire [8:0] level
);
  timeunit 1ns;
  timeprecision 100ps;
  // Released line rises to the pull-up level
  assign level = ~drive_en;
endmodule // led_pin_loads

//--- verification/led_pwm_checker_sva.sv
/* Checker: bus answers, pin drive and frame timing of the PWM block.
   Assumes it is bound to the top module and sees its ports only. */
module led_pwm_checker #(
  parameter STEP_DIV = 2,
  parameter NUM_OUT = 9
) (
  input wire CLK,
  input wire RST,
  input wire HSEL,
  input wire [31:0] HADDR,
  input wire [1:0] HTRANS,
  input wire HWRITE,
  input wire [31:0] HWDATA,
  input wire HREADY,
  input wire [31:0] HRDATA,
  input wire HREADYOUT,
  input wire HRESP,
  input wire [NUM_OUT-1:0] PORT_OUT,
  input wire [NUM_OUT-1:0] PORT_OE
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int FRAME = 240 * STEP_DIV;
  reg wr_pend;
  reg [7:0] wr_idx;
  reg [7:0] master_q;
  reg [11:0] quiet;
  wire take = HSEL && HREADY && HTRANS[1];
  wire rd_take = take && !HWRITE;
  // Master register mirror and cycles since the last write
  always @(posedge CLK) begin
    if (RST) begin
      wr_pend <= 1'b0;
      master_q <= 8'h00;
      quiet <= 12'h000;
    end else begin
      wr_pend <= take && HWRITE;
      wr_idx <= HADDR[9:2];
      if (wr_pend && wr_idx == 8'h0e)
        master_q <= HWDATA[7:0];
      if (wr_pend)
        quiet <= 12'h000;
      else if (quiet != 12'hfff)
        quiet <= quiet + 12'h001;
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  a_resp_okay: assert property (HRESP == 1'b0)
    else $error("error response seen");
  a_ready_high: assert property (HREADYOUT == 1'b1)
    else $error("wait state seen");
  a_oe_tracks_out: assert property (PORT_OE == PORT_OUT)
    else $error("enable differs from drive");
  a_unmapped_zero: assert property (rd_take && HADDR[9:2] == 8'h3c |=> HRDATA == 32'h0)
    else $error("unmapped read not zero");
  a_master_readback: assert property (
    rd_take && HADDR[9:2] == 8'h0e && !wr_pend |=> HRDATA[7:0] == master_q)
    else $error("master read-back wrong");
  a_rdata_stands: assert property (!rd_take |=> $stable(HRDATA))
    else $error("read data moved");
  a_static_steady: assert property (
    master_q[7:4] == 4'h0 && quiet >= 12'd4 |-> $stable(PORT_OUT))
    else $error("pulse in static mode");
  a_frame_repeat: assert property (
    master_q[7:4] != 4'h0 && quiet >= 3 * FRAME |-> PORT_OUT == $past(PORT_OUT, FRAME))
    else $error("pattern not periodic");
  c_pwm_frame: cover property (master_q[7:4] != 4'h0 && quiet == 12'd1440);
  c_static: cover property (master_q[7:4] == 4'h0 && quiet == 12'd4);
  c_read_master: cover property (rd_take && HADDR[9:2] == 8'h0e);
endmodule // led_pwm_checker

bind led_pwm_intensity_control led_pwm_checker #(.STEP_DIV(STEP_DIV), .NUM_OUT(NUM_OUT))
  led_pwm_checker_i (.CLK(CLK), .RST(RST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
  .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA),
  .HREADYOUT(HREADYOUT), .HRESP(HRESP), .PORT_OUT(PORT_OUT), .PORT_OE(PORT_OE));

//--- verification/tb_top.sv
/* Bench: register traffic, reset values and per-output low time per frame.
   Assumes the design files and the pin model are compiled first. */
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int SD = 2;
  localparam int FR = 240 * SD;
  reg clk;
  reg rst;
  reg hsel;
  reg hwrite;
  reg [1:0] htrans;
  reg [2:0] hsize;
  reg [31:0] haddr;
  reg [31:0] hwdata;
  wire [31:0] hrdata;
  wire hreadyout;
  wire hresp;
  wire [8:0] port_in;
  wire [8:0] port_out;
  wire [8:0] port_oe;
  int errors = 0;
  int checks = 0;
  int mt[6] = '{0, 1, 15, 7, 15, 3};
  reg [7:0] seed;
  reg [31:0] rd;
  reg [3:0] codes[9];

  led_pwm_intensity_control #(.STEP_DIV(SD), .NUM_OUT(9)) led_pwm_intensity_control_i (
    .CLK(clk), .RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
    .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
    .HREADYOUT(hreadyout), .HRESP(hresp), .PORT_IN(port_in), .PORT_OUT(port_out),
    .PORT_OE(port_oe));
  led_pin_loads led_pin_loads_i (.drive_en(port_oe), .level(port_in));

  function automatic [7:0] lfsr(input [7:0] v);
    lfsr = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction

  // Low cycles per frame: gated slots times on-time, inverted by phase
  function automatic int exp_low(int m, int code, int ph);
    int on;
    on = m * (code + 1) * SD;
    if (m == 0 || code == 15)
      on = FR;
    exp_low = ph ? FR - on : on;
  endfunction

  task automatic chk(input [31:0] seen, input [31:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // One single AHB-Lite transfer, idle cycle before it
  task automatic bus(input w, input [7:0] idx, input [31:0] wd, output [31:0] rdv);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {22'h0, idx, 2'b00};
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rdv = hrdata;
    hsel <= 1'b0;
  endtask

  task automatic wrap_up();
    if (errors == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Watchdog
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    wrap_up();
  end

  // Reset values, then six intensity setups measured over one frame
  initial begin
    int g, np, k, it, e;
    int cnt[9];
    reg [7:0] p0;
    reg [7:0] c9;
    reg [7:0] ib;
    rst = 1'b1;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'b00;
    hsize = 3'b010;
    haddr = 32'h0;
    hwdata = 32'h0;
    seed = 8'h12;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    bus(0, 8'h0e, 0, rd);
    chk(rd, 32'h00, "master");
    bus(0, 8'h0f, 0, rd);
    chk(rd, 32'h30, "config");
    bus(0, 8'h13, 0, rd);
    chk(rd, 32'hff, "intensity");
    bus(0, 8'h3c, 0, rd);
    chk(rd, 32'h00, "unmapped");
    for (it = 0; it < 6; it++) begin
      for (k = 0; k < 4; k++) begin
        seed = lfsr(seed);
        ib = (k == 0) ? 8'hef : seed;
        codes[2 * k] = ib[3:0];
        codes[2 * k + 1] = ib[7:4];
        bus(1, 8'h10 + k[7:0], {24'h0, ib}, rd);
      end
      seed = lfsr(seed);
      p0 = seed;
      seed = lfsr(seed);
      c9 = seed;
      np = c9[4];
      g = (it >= 4);
      bus(1, 8'h01, {24'h0, p0}, rd);
      bus(1, 8'h0f, {26'h0, 1'b1, np[0], 1'b0, g[0], 2'b00}, rd);
      bus(1, 8'h0e, {24'h0, mt[it][3:0], c9[3:0]}, rd);
      repeat (3 * FR) @(posedge clk);
      for (k = 0; k < 9; k++)
        cnt[k] = 0;
      repeat (FR) begin
        @(negedge clk);
        for (k = 0; k < 9; k++)
          cnt[k] += port_out[k];
      end
      for (k = 0; k < 9; k++) begin
        e = exp_low(mt[it], (g || k == 8) ? c9[3:0] : codes[k], (k == 8) ? np : p0[k]);
        chk(cnt[k], e, "low count");
      end
      if (it == 0) begin
        bus(0, 8'h00, 0, rd);
        chk(rd, {23'h0, np[0], p0}, "pins");
      end
    end
    // Static again, blink flip selects phase 1 for the pin levels
    seed = lfsr(seed);
    bus(1, 8'h0e, 0, rd);
    bus(1, 8'h09, {24'h0, seed}, rd);
    bus(1, 8'h0f, 32'h23, rd);
    repeat (8) @(posedge clk);
    bus(0, 8'h00, 0, rd);
    chk(rd, {23'h0, 1'b1, seed}, "pins phase 1");
    bus(0, 8'h20, 0, rd);
    chk(rd, 32'h0, "status");
    wrap_up();
  end
endmodule // tb_top
